// [verilog/lcc_codec.sv]
// top: loopback steering, composite clock codec and 6312 kHz sync output
// Notes on behaviour
// - remote loop bit sends received line data to the transmit line unit
// - in remote loop the receive path still runs; formatter data is dropped
// - local loop feeds transmitted data into the receive path
// - locally looped data passes the jitter attenuator when it is enabled
// - composite receive recovers 64k, 8k and 400 Hz clocks
// - subrate clocks come from presence or absence of violations
// - violation every 8k frame; 400 Hz variant omits one per period
// - two formats: 64k+8k and 64k+8k+400
// - composite transmit makes 64k bipolar waveform with placed violations
// - violations align to the transmit 8k sync input when present
// - without sync input, violations free run at 8k
// - 6312 kHz receive mode outputs a square wave on receive clock
// - 6312 kHz mode leaves 8k and 400 Hz outputs undriven
// - transmit clock out is synth square, or recovered clock in remote loop
// - 6312 kHz mode leaves transmit line pair undriven
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module lcc_codec (
    input  wire logic               clock,
    input  wire logic               rst,
    // classic wishbone slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // hardware control
    input  wire logic               remote_loop_pin,
    // receive line pair (sliced marks)
    input  wire logic               receive_line_tip,
    input  wire logic               receive_line_ring,
    // transmit formatter data and sync
    input  wire lcc_pkg::lcc_line_t fmt_tx_data,
    input  wire logic               transmit_8k_sync_in,
    input  wire logic               recovered_rx_clock,
    // transmit line pair
    output logic                    transmit_line_tip,
    output logic                    transmit_line_ring,
    output logic                    transmit_line_oe,
    output logic                    transmit_clock_out,
    // receive side outputs
    output lcc_pkg::lcc_line_t      framer_rx_data,
    output logic                    receive_clock_out,
    output logic                    receive_8k_sync_out,
    output logic                    receive_8k_sync_oe,
    output logic                    receive_400_out,
    output logic                    receive_400_oe
);
    import lcc_pkg::*;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] loopback_control_q;
    logic [7:0] mode_q;
    logic       ack_q;
    logic [31:0] rdat_q;
    logic       remote_loop_enable;
    logic       local_loop_enable;
    lcc_mode_t  mode;
    logic       hw_mode;
    logic       wr_en;
    logic [7:0] status;
    logic       rx8k;
    logic       rx400;
    logic       rx64;
    logic       sync_lock_q;

    assign hw_mode = mode_q[HW_MODE_BIT];
    assign remote_loop_enable = hw_mode ? remote_loop_pin
                                        : loopback_control_q[REMOTE_LOOP_BIT];
    assign local_loop_enable  = hw_mode ? 1'b0 : loopback_control_q[LOCAL_LOOP_BIT];
    assign mode = (mode_q[1:0] == 2'h1) ? MODE_CC64 :
                  (mode_q[1:0] == 2'h2) ? MODE_SQ6312 : MODE_OFF;
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
    assign status = {5'h00, sync_lock_q, rx400, rx8k};

    always_ff @(posedge clock) begin
        if (rst) begin
            loopback_control_q <= LOOP_CTRL_RESET;
            mode_q             <= MODE_CTRL_RESET;
        end else if (wr_en) begin
            // unused bits are stored as written; software keeps them zero
            if (wb_adr_i == LOOP_CTRL_OFFSET) begin
                loopback_control_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == MODE_CTRL_OFFSET) begin
                mode_q <= wb_dat_i[7:0];
            end
        end
    end

    // one wait state; ack drops the cycle after it is given
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end else begin
            ack_q  <= wb_cyc_i && wb_stb_i && !ack_q;
            rdat_q <= '0;
            if (wb_cyc_i && wb_stb_i && !ack_q) begin
                unique case (wb_adr_i)
                    LOOP_CTRL_OFFSET: rdat_q <= {24'h000000, loopback_control_q};
                    MODE_CTRL_OFFSET: rdat_q <= {24'h000000, mode_q};
                    STATUS_OFFSET:    rdat_q <= {24'h000000, status};
                    default:          rdat_q <= '0;
                endcase
            end
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ---------------------------------------------------------------
    // composite clock transmit generator
    // ---------------------------------------------------------------
    logic [10:0] bit_cnt_q;
    logic [2:0] bit_idx_q;
    logic [4:0] frame_idx_q;
    logic       pol_q;
    logic       sync_d1_q;
    logic [4:0] sync_age_q;
    logic       sync_rise;
    lcc_line_t  cc_sym_q;
    logic       bit_tick;
    logic       omit;

    assign sync_rise = transmit_8k_sync_in && !sync_d1_q;
    assign bit_tick  = (bit_cnt_q == 11'(BIT_CYCLES - 1));
    // 400 Hz format drops the violation of one frame in twenty
    assign omit = mode_q[FMT400_BIT] && (frame_idx_q == '0);

    always_ff @(posedge clock) begin
        if (rst) begin
            sync_d1_q   <= 1'b0;
            sync_age_q  <= '0;
            sync_lock_q <= 1'b0;
        end else begin
            sync_d1_q <= transmit_8k_sync_in;
            if (sync_rise) begin
                sync_age_q  <= '0;
                sync_lock_q <= 1'b1;
            end else if (bit_tick && sync_age_q != 5'(SYNC_TIMEOUT)) begin
                sync_age_q <= sync_age_q + 5'h01;
            end else if (sync_age_q == 5'(SYNC_TIMEOUT)) begin
                sync_lock_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bit_cnt_q   <= '0;
            bit_idx_q   <= '0;
            frame_idx_q <= '0;
            pol_q       <= 1'b0;
            cc_sym_q    <= '0;
        end else if (mode != MODE_CC64) begin
            bit_cnt_q <= '0;
            cc_sym_q  <= '0;
        end else begin
            if (sync_rise && sync_lock_q) begin
                bit_cnt_q <= '0;
                bit_idx_q <= '0;
            end else if (bit_tick) begin
                bit_cnt_q <= '0;
                bit_idx_q <= bit_idx_q + 3'h1;
                if (bit_idx_q == 3'(BITS_PER_8K - 1)) begin
                    frame_idx_q <= (frame_idx_q == 5'(FRAMES_PER_400 - 1)) ? '0 : frame_idx_q + 5'h01;
                end
            end else begin
                bit_cnt_q <= bit_cnt_q + 11'h001;
            end
            // mark for first 5/8 of the bit, space for the rest
            if (bit_cnt_q == '0) begin
                // violation repeats the last polarity on bit 0 of a frame
                if (bit_idx_q == '0 && !omit) begin
                    cc_sym_q <= pol_q ? 2'b10 : 2'b01;
                end else begin
                    cc_sym_q <= pol_q ? 2'b01 : 2'b10;
                    pol_q    <= !pol_q;
                end
            end else if (bit_cnt_q == 11'(BIT_CYCLES * 5 / 8)) begin
                cc_sym_q <= '0;
            end
        end
    end

    // ---------------------------------------------------------------
    // 6312 kHz square wave synthesis
    // ---------------------------------------------------------------
    logic [3:0] sq_cnt_q;
    logic       sq_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            sq_cnt_q <= '0;
            sq_q     <= 1'b0;
        end else if (sq_cnt_q == 4'(SQ_HALF - 1)) begin
            sq_cnt_q <= '0;
            sq_q     <= !sq_q;
        end else begin
            sq_cnt_q <= sq_cnt_q + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // loopback steering
    // ---------------------------------------------------------------
    lcc_line_t rx_line;
    lcc_line_t tx_src;
    lcc_line_t tx_line_d;
    lcc_line_t ja_out;
    lcc_line_t local_fb;
    lcc_line_t rx_path;
    lcc_line_t tx_q;

    assign rx_line = '{pos: receive_line_tip, neg: receive_line_ring};
    assign tx_src  = (mode == MODE_CC64) ? cc_sym_q : fmt_tx_data;
    // remote loop replaces formatter data with received data
    assign tx_line_d = remote_loop_enable ? rx_line : tx_src;

    lcc_delay u_ja (
        .clock (clock),
        .rst   (rst),
        .din   (tx_q),
        .dout  (ja_out)
    );
    assign local_fb = mode_q[JA_ENABLE_BIT] ? ja_out : tx_q;
    assign rx_path  = local_loop_enable ? local_fb : rx_line;

    lcc_cc_rx u_rx (
        .clock    (clock),
        .rst      (rst),
        .line_in  (rx_path),
        .clk64_q  (rx64),
        .clk8k_q  (rx8k),
        .clk400_q (rx400)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_q               <= '0;
            transmit_line_tip  <= 1'b0;
            transmit_line_ring <= 1'b0;
            transmit_line_oe   <= 1'b0;
            transmit_clock_out <= 1'b0;
        end else begin
            tx_q               <= tx_line_d;
            transmit_line_tip  <= tx_line_d.pos;
            transmit_line_ring <= tx_line_d.neg;
            transmit_line_oe   <= (mode != MODE_SQ6312);
            transmit_clock_out <= remote_loop_enable ? recovered_rx_clock : sq_q;
        end
    end

    // receive outputs; framer keeps seeing received data in remote loop
    always_ff @(posedge clock) begin
        if (rst) begin
            framer_rx_data      <= '0;
            receive_clock_out   <= 1'b0;
            receive_8k_sync_out <= 1'b0;
            receive_8k_sync_oe  <= 1'b0;
            receive_400_out     <= 1'b0;
            receive_400_oe      <= 1'b0;
        end else begin
            framer_rx_data      <= rx_path;
            receive_clock_out   <= (mode == MODE_SQ6312) ? sq_q : rx64;
            receive_8k_sync_out <= rx8k;
            receive_400_out     <= rx400;
            receive_8k_sync_oe  <= (mode != MODE_SQ6312);
            receive_400_oe      <= (mode != MODE_SQ6312);
        end
    end
endmodule : lcc_codec
`default_nettype wire

// [verilog/lcc_pkg.sv]
// package: constants and carriers for the loopback and sync clock codec
`default_nettype none
package lcc_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] LOOP_CTRL_OFFSET = 8'h20;
    localparam logic [7:0] MODE_CTRL_OFFSET = 8'h24;
    localparam logic [7:0] STATUS_OFFSET    = 8'h28;
    localparam logic [7:0] LOOP_CTRL_RESET  = 8'h00;
    localparam logic [7:0] MODE_CTRL_RESET  = 8'h00;
    localparam int REMOTE_LOOP_BIT = 2;
    localparam int LOCAL_LOOP_BIT  = 3;
    // mode control fields
    localparam int MODE_LSB       = 0;
    localparam int FMT400_BIT     = 2;
    localparam int JA_ENABLE_BIT  = 3;
    localparam int HW_MODE_BIT    = 4;
    // status fields
    localparam int ST_RX8K_BIT    = 0;
    localparam int ST_RX400_BIT   = 1;
    localparam int ST_SYNCLOCK_BIT = 2;

    // ---------------------------------------------------------------
    // timing at 100 MHz
    // ---------------------------------------------------------------
    localparam int CLK_KHZ        = 100000;
    localparam int BIT_KHZ        = 64;
    localparam int SQ_KHZ         = 6312;
    localparam int BIT_CYCLES     = CLK_KHZ / BIT_KHZ;
    localparam int HALF_BIT       = BIT_CYCLES / 2;
    localparam int SQ_HALF        = CLK_KHZ / (2 * SQ_KHZ);
    localparam int BITS_PER_8K    = 8;
    localparam int FRAMES_PER_400 = 20;
    localparam int SYNC_TIMEOUT   = 2 * BITS_PER_8K;
    localparam int JA_DEPTH       = 4;

    typedef enum logic [1:0] {
        MODE_OFF, MODE_CC64, MODE_SQ6312
    } lcc_mode_t;

    typedef struct packed {
        logic pos;
        logic neg;
    } lcc_line_t;
endpackage : lcc_pkg
`default_nettype wire

// [verilog/lcc_delay.sv]
// jitter attenuator stand-in: fixed delay line for line symbols
`timescale 1ns/1ps
`default_nettype none
module lcc_delay (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire lcc_pkg::lcc_line_t din,
    output lcc_pkg::lcc_line_t      dout
);
    import lcc_pkg::*;
    lcc_line_t stage_q [JA_DEPTH];
    genvar i;
    generate
        for (i = 0; i < JA_DEPTH; i++) begin : g_stage
            always_ff @(posedge clock) begin
                if (rst) begin
                    stage_q[i] <= '0;
                end else begin
                    stage_q[i] <= (i == 0) ? din : stage_q[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate
    assign dout = stage_q[JA_DEPTH-1];
endmodule : lcc_delay
`default_nettype wire

// [verilog/lcc_cc_rx.sv]
// composite clock receive decoder: recovers 64k, 8k and 400 Hz
`timescale 1ns/1ps
`default_nettype none
module lcc_cc_rx (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire lcc_pkg::lcc_line_t line_in,
    output logic                    clk64_q,
    output logic                    clk8k_q,
    output logic                    clk400_q
);
    import lcc_pkg::*;
    lcc_line_t prev_q;
    logic      last_pol_q;      // polarity of last mark
    logic [4:0] frame_q;
    logic [3:0] gap_q;
    logic       mark;
    logic       viol;
    assign mark = (line_in.pos ^ line_in.neg) && !(prev_q.pos || prev_q.neg);
    // violation: mark with same polarity as the previous mark
    assign viol = mark && (line_in.pos == last_pol_q);
    always_ff @(posedge clock) begin
        if (rst) begin
            prev_q     <= '0;
            last_pol_q <= 1'b0;
            clk64_q    <= 1'b0;
        end else begin
            prev_q <= line_in;
            if (mark) begin
                last_pol_q <= line_in.pos;
                clk64_q    <= 1'b1;
            end else if (!(line_in.pos || line_in.neg)) begin
                clk64_q <= 1'b0;
            end
        end
    end
    // 8k from violations; a missing violation marks the 400 Hz epoch
    always_ff @(posedge clock) begin
        if (rst) begin
            gap_q    <= '0;
            frame_q  <= '0;
            clk8k_q  <= 1'b0;
            clk400_q <= 1'b0;
        end else if (mark) begin
            if (viol) begin
                gap_q   <= '0;
                clk8k_q <= 1'b1;
            end else begin
                gap_q   <= gap_q + 4'h1;
                if (gap_q == 4'(BITS_PER_8K/2 - 1)) begin
                    clk8k_q <= 1'b0;
                end
                if (gap_q == 4'(BITS_PER_8K - 1)) begin
                    gap_q    <= '0;
                    frame_q  <= '0;
                    clk400_q <= 1'b1;
                end
            end
            if (viol) begin
                frame_q <= (frame_q == 5'(FRAMES_PER_400 - 1)) ? '0 : frame_q + 5'h01;
                if (frame_q == 5'(FRAMES_PER_400/2 - 1)) begin
                    clk400_q <= 1'b0;
                end
            end
        end
    end
endmodule : lcc_cc_rx
`default_nettype wire

// [dv/lcc_codec_chk.sv]
// checker: port-level properties of the loopback and sync clock codec
`timescale 1ns/1ps
`default_nettype none
module lcc_codec_chk (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        transmit_line_tip,
    input wire logic        transmit_line_ring,
    input wire logic        transmit_line_oe,
    input wire logic        receive_clock_out,
    input wire logic        receive_8k_sync_oe,
    input wire logic        receive_400_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    property p_ack_answer; s_req |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("no ack one cycle after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_rd_upper; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_rd_upper: assert property (p_rd_upper)
        else $error("upper read bytes not zero");
    // ------------------------------------------------------------
    // line and mode outputs
    // ------------------------------------------------------------
    property p_one_mark; !(transmit_line_tip && transmit_line_ring); endproperty
    a_one_mark: assert property (p_one_mark)
        else $error("both transmit marks active");
    property p_sub_oe; receive_8k_sync_oe == receive_400_oe; endproperty
    a_sub_oe: assert property (p_sub_oe)
        else $error("subrate enables disagree");
    property p_line_oe; transmit_line_oe == receive_8k_sync_oe; endproperty
    a_line_oe: assert property (p_line_oe)
        else $error("line enable disagrees with subrate enable");
    // a toggle well inside 6312 mode starts a full half period of 6 to 8 cycles
    sequence s_sq_edge; !transmit_line_oe [*3] ##0 $changed(receive_clock_out); endsequence
    property p_sq_half;
        s_sq_edge |=> ($stable(receive_clock_out) || transmit_line_oe) [*5]
            ##[1:3] ($changed(receive_clock_out) || transmit_line_oe);
    endproperty
    a_sq_half: assert property (p_sq_half)
        else $error("square half period out of range");
endmodule : lcc_codec_chk

bind lcc_codec lcc_codec_chk lcc_codec_chk_i (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .transmit_line_tip(transmit_line_tip),
    .transmit_line_ring(transmit_line_ring), .transmit_line_oe(transmit_line_oe),
    .receive_clock_out(receive_clock_out), .receive_8k_sync_oe(receive_8k_sync_oe),
    .receive_400_oe(receive_400_oe)
);
`default_nettype wire

// [dv/lcc_cc_source.sv]
// partner: composite clock line source, all-ones bipolar with 8k violations
`timescale 1ns/1ps
`default_nettype none
module lcc_cc_source
    import lcc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic fmt400,
    output logic      tip,
    output logic      ring
);
    int unsigned tick_q;
    int unsigned bit_q;
    int unsigned frame_q;
    logic        pol_q;
    logic        mark;
    logic        use_pos;
    // mark for 5/8 of the bit, line at rest between marks
    assign mark = tick_q < (BIT_CYCLES * 5) / 8;
    // violation repeats the last polarity; skipped once per 400 Hz period in that format
    assign use_pos = (bit_q == 0 && !(fmt400 && frame_q == 0)) ? pol_q : !pol_q;
    always_ff @(posedge clock) begin
        if (rst || !enable) begin
            tick_q <= 0;
            bit_q <= 0;
            frame_q <= 0;
            pol_q <= 1'b0;
        end else if (tick_q == BIT_CYCLES - 1) begin
            tick_q <= 0;
            pol_q <= use_pos;
            bit_q <= (bit_q + 1) % BITS_PER_8K;
            if (bit_q == BITS_PER_8K - 1) frame_q <= (frame_q + 1) % FRAMES_PER_400;
        end else tick_q <= tick_q + 1;
    end
    assign tip = enable && mark && use_pos;
    assign ring = enable && mark && !use_pos;
endmodule : lcc_cc_source
`default_nettype wire

// [dv/lcc_codec_test.sv]
// testbench: registers, loopback paths, 6312 kHz and composite clock modes
`timescale 1ns/1ps
`default_nettype none
module lcc_codec_test;
    import lcc_pkg::*;
    logic        clock = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, p_tip, p_ring, transmit_line_tip, transmit_line_ring, transmit_line_oe;
    logic        remote_loop_pin = 1'b0, tb_tip = 1'b0, tb_ring = 1'b0, use_part = 1'b0;
    logic        recovered_rx_clock = 1'b0, transmit_clock_out, receive_clock_out, receive_8k_sync_out;
    logic        receive_8k_sync_oe, receive_400_out, receive_400_oe, last_pos = 1'b0;
    lcc_line_t   fmt_tx_data = '0, framer_rx_data;
    logic [31:0] seed = 32'hF157102F;
    logic [31:0] q_bus[$];
    logic [3:0]  q_line[$];
    logic [3:0]  e;
    logic [5:0]  prev = 6'h0;
    int          bad_count = 0, cmp_count = 0, cyc_n = 0, rec_div = 0;
    int          n_rclk = 0, n_tclk = 0, n_rec = 0, n_8k = 0, n_mark = 0, n_viol = 0;
    int          c[6];

    lcc_codec lcc_codec_i (
        .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .remote_loop_pin(remote_loop_pin),
        .receive_line_tip(use_part ? p_tip : tb_tip), .receive_line_ring(use_part ? p_ring : tb_ring),
        .fmt_tx_data(fmt_tx_data), .transmit_8k_sync_in(1'b0), .recovered_rx_clock(recovered_rx_clock),
        .transmit_line_tip(transmit_line_tip), .transmit_line_ring(transmit_line_ring),
        .transmit_line_oe(transmit_line_oe), .transmit_clock_out(transmit_clock_out),
        .framer_rx_data(framer_rx_data), .receive_clock_out(receive_clock_out),
        .receive_8k_sync_out(receive_8k_sync_out), .receive_8k_sync_oe(receive_8k_sync_oe),
        .receive_400_out(receive_400_out), .receive_400_oe(receive_400_oe)
    );
    lcc_cc_source lcc_cc_source_i (
        .clock(clock), .rst(rst), .enable(use_part), .fmt400(1'b0), .tip(p_tip), .ring(p_ring)
    );

    always #5 clock = ~clock;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] sym();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return (seed[1:0] == 2'h3) ? 2'h0 : seed[1:0];
    endfunction : sym
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : rng
    task automatic wb(input logic [7:0] a, input logic we, input logic [7:0] d);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= 4'h1;
        do begin
            @(posedge clock);
        end while (!wb_ack_o);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        q_bus.push_back({24'h0, x});
        wb(a, 1'b0, 8'h00);
    endtask : rd
    // random symbols on both sides; notes which source each output must echo and how late
    task automatic stream(input bit tx_rx, input bit fr_fmt, input int lag);
        logic [1:0] hr[8];
        logic [1:0] hf[8];
        for (int i = 0; i < 48; i++) begin
            @(posedge clock);
            for (int k = 7; k > 0; k--) begin
                hr[k] = hr[k-1];
                hf[k] = hf[k-1];
            end
            hr[0] = sym();
            hf[0] = sym();
            {tb_tip, tb_ring} <= hr[0];
            fmt_tx_data <= lcc_line_t'(hf[0]);
            if (i >= 8) q_line.push_back({tx_rx ? hr[1] : hf[1], fr_fmt ? hf[lag] : hr[lag]});
        end
    endtask : stream
    task automatic snap();
        c = '{n_rclk, n_tclk, n_rec, n_8k, n_mark, n_viol};
    endtask : snap
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // monitors
    // ------------------------------------------------------------
    always @(negedge clock) begin
        if (wb_ack_o && !wb_we_i && q_bus.size() > 0) chk(wb_dat_o, q_bus.pop_front());
        if (q_line.size() > 0) begin
            e = q_line.pop_front();
            chk({30'h0, transmit_line_tip, transmit_line_ring}, {30'h0, e[3:2]});
            chk({30'h0, framer_rx_data}, {30'h0, e[1:0]});
        end
    end
    always @(posedge clock) begin
        rec_div = (rec_div + 1) % 25;
        if (rec_div == 0) recovered_rx_clock <= !recovered_rx_clock;
        n_rclk += int'(receive_clock_out && !prev[5]);
        n_tclk += int'(transmit_clock_out && !prev[4]);
        n_8k += int'(receive_8k_sync_out && !prev[3]);
        n_rec += int'(recovered_rx_clock && !prev[2]);
        if ((transmit_line_tip || transmit_line_ring) && prev[1:0] == 2'h0) begin
            n_mark++;
            if (transmit_line_tip == last_pos) n_viol++;
            last_pos = transmit_line_tip;
        end
        prev = {receive_clock_out, transmit_clock_out, receive_8k_sync_out, recovered_rx_clock,
                transmit_line_tip, transmit_line_ring};
        cyc_n++;
        // the whole run needs about 52400 cycles
        if (cyc_n == 80000) begin
            bad_count++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rd(8'h20, 8'h00);
        rd(8'h24, 8'h00);
        wb(8'h30, 1'b1, 8'hFF);
        rd(8'h30, 8'h00);
        stream(1'b0, 1'b0, 1);
        wb(8'h20, 1'b1, 8'h04);
        rd(8'h20, 8'h04);
        stream(1'b1, 1'b0, 1);
        wb(8'h20, 1'b1, 8'h08);
        rd(8'h20, 8'h08);
        stream(1'b0, 1'b1, 2);
        wb(8'h24, 1'b1, 8'h08);
        stream(1'b0, 1'b1, 6);
        wb(8'h24, 1'b1, 8'h10);
        remote_loop_pin <= 1'b1;
        stream(1'b1, 1'b0, 1);
        remote_loop_pin <= 1'b0;
        stream(1'b0, 1'b0, 1);
        wb(8'h20, 1'b1, 8'h00);
        wb(8'h24, 1'b1, 8'h02);
        repeat (20) @(posedge clock);
        snap();
        repeat (1000) @(posedge clock);
        rng(n_rclk - c[0], 60, 72);
        rng(n_tclk - c[1], 60, 72);
        chk({31'h0, transmit_line_oe}, 32'h0);
        chk({31'h0, receive_8k_sync_oe | receive_400_oe}, 32'h0);
        wb(8'h20, 1'b1, 8'h04);
        repeat (20) @(posedge clock);
        snap();
        repeat (1000) @(posedge clock);
        rng(n_tclk - c[1], n_rec - c[2] - 1, n_rec - c[2] + 1);
        wb(8'h20, 1'b1, 8'h00);
        wb(8'h24, 1'b1, 8'h01);
        use_part <= 1'b1;
        repeat (12500) @(posedge clock);
        snap();
        repeat (37488) @(posedge clock);
        rng(n_rclk - c[0], 23, 25);
        rng(n_8k - c[3], 2, 4);
        rng(n_mark - c[4], 23, 25);
        rng(n_viol - c[5], 2, 4);
        chk({31'h0, receive_8k_sync_oe}, 32'h1);
        final_report();
    end
endmodule : lcc_codec_test
`default_nettype wire
